// file: inc/apdu_pkg.sv
// constants, types and state record for the contactless command interpreter
`default_nettype none
package apdu_pkg;
    localparam logic [7:0]  CLA_OK       = 8'h00;
    localparam logic [7:0]  INS_SELECT   = 8'hA4;
    localparam logic [7:0]  INS_READ     = 8'hB0;
    localparam logic [7:0]  INS_WRITE    = 8'hD6;
    localparam logic [7:0]  SEL_P1_EF    = 8'h02;
    localparam logic [7:0]  SEL_P2_NOFCI = 8'h0C;
    localparam logic [7:0]  SEL_LC       = 8'h02;
    localparam logic [7:0]  RD_LE_MIN    = 8'h01;
    localparam logic [7:0]  RD_LE_MAX    = 8'hFB;
    localparam logic [7:0]  WR_LC_MIN    = 8'h01;
    localparam logic [7:0]  WR_LC_MAX    = 8'hF8;
    localparam logic [7:0]  CNT_SAT      = 8'hFF;
    localparam logic [2:0]  HDR_LEN      = 3'h5;
    localparam int          MEM_AW       = 11;
    localparam logic [16:0] MEM_BYTES    = 17'h00800;
    localparam logic [1:0]  BUF_DEPTH    = 2'h2;
    // status words: implementation values
    localparam logic [15:0] SW_NORMAL    = 16'h9000;
    localparam logic [15:0] SW_WRONG_LEN = 16'h6700;
    localparam logic [15:0] SW_BAD_CLA   = 16'h6E00;
    localparam logic [15:0] SW_BAD_INS   = 16'h6D00;
    localparam logic [15:0] SW_BAD_P1P2  = 16'h6A86;
    localparam logic [15:0] SW_BAD_ADDR  = 16'h6A82;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } apdu_byte_t;

    typedef struct packed {
        logic [7:0] cla;
        logic [7:0] ins;
        logic [7:0] p1;
        logic [7:0] p2;
        logic [7:0] p3;
    } apdu_hdr_t;

    typedef enum logic [2:0] {
        ST_HDR, ST_BODY, ST_EVAL, ST_RD_MEM, ST_RD_TUN, ST_SW1, ST_SW2
    } apdu_state_t;

    typedef struct packed {
        apdu_state_t      state;
        apdu_hdr_t        hdr;
        logic [2:0]       hdr_cnt;
        logic [7:0]       body_cnt;
        logic [7:0]       left;
        logic [15:0]      sw;
        logic [15:0]      ptr;
        apdu_byte_t [1:0] buf_q;
        logic [1:0]       buf_cnt;
        logic             rsp_valid;
        logic             cmd_ready;
        logic             tun_rd_ready;
        logic             tun_rd_req;
        logic             tun_wr_valid;
        apdu_byte_t       tun_wr;
    } apdu_reg_t;

    localparam apdu_reg_t REG_RST = '0;
endpackage : apdu_pkg
`default_nettype wire

// file: hw/apdu_select_read_write.sv
// select, read and write command interpreter with two-entry response buffer
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - valid select returns normal status and does nothing else.
// - class byte other than zero gives an error status.
// - select with first parameter not 0x02 gives an error.
// - select with second parameter not 0x0C gives an error.
// - select needs length byte two and two data bytes, else error.
// - select file identifier bytes are never looked at.
// - read start address is formed from both parameter bytes.
// - read data precedes status only on normal status, else omitted.
// - in tunnel mode read data comes from the wired host.
// - write start address is formed from both parameter bytes.
// - outside tunnel mode write data goes to memory, reply is status only.
// - in tunnel mode write data goes to the wired host.
// - response is sent only after the whole command is processed.
module apdu_select_read_write (
    input  wire logic                core_clk_in,
    input  wire logic                rst_b_in,
    input  wire logic                tunnel_mode_in,
    input  wire apdu_pkg::apdu_byte_t cmd_in,
    input  wire logic                cmd_valid_in,
    output logic                     cmd_ready_out,
    output apdu_pkg::apdu_byte_t     rsp_out,
    output logic                     rsp_valid_out,
    input  wire logic                rsp_ready_in,
    output logic                     tun_rd_req_out,
    output logic [15:0]              tun_rd_addr_out,
    output logic [7:0]               tun_rd_len_out,
    input  wire logic [7:0]          tun_rd_data_in,
    input  wire logic                tun_rd_valid_in,
    output logic                     tun_rd_ready_out,
    output apdu_pkg::apdu_byte_t     tun_wr_out,
    output logic                     tun_wr_valid_out
);
    apdu_pkg::apdu_reg_t st;
    apdu_pkg::apdu_reg_t next_st;
    logic [7:0]          mem [0:(1 << apdu_pkg::MEM_AW) - 1];
    logic                mem_we;
    logic [apdu_pkg::MEM_AW-1:0] mem_wa;
    logic [7:0]          mem_wd;
    logic [7:0]          mem_q;
    logic                pop;
    logic                push;
    logic                room;
    logic                cmd_take;
    logic                tun_take;
    logic [1:0]          widx;
    logic [15:0]         wr_addr;
    apdu_pkg::apdu_byte_t push_byte;

    function automatic logic [16:0] end_addr(input apdu_pkg::apdu_hdr_t h);
        end_addr = {1'b0, h.p1, h.p2} + {9'h000, h.p3};
    endfunction : end_addr

    function automatic logic write_ok(input apdu_pkg::apdu_hdr_t h, input logic tun);
        write_ok = h.cla == apdu_pkg::CLA_OK && h.ins == apdu_pkg::INS_WRITE
                   && h.p3 >= apdu_pkg::WR_LC_MIN && h.p3 <= apdu_pkg::WR_LC_MAX
                   && (tun || end_addr(h) <= apdu_pkg::MEM_BYTES);
    endfunction : write_ok

    function automatic logic [15:0] check_cmd(input apdu_pkg::apdu_hdr_t h, input logic [2:0] nh,
                                              input logic [7:0] nb, input logic tun);
        if (nh != apdu_pkg::HDR_LEN) begin
            check_cmd = apdu_pkg::SW_WRONG_LEN;
        end else if (h.cla != apdu_pkg::CLA_OK) begin
            check_cmd = apdu_pkg::SW_BAD_CLA;
        end else begin
            unique case (h.ins)
                apdu_pkg::INS_SELECT: begin
                    if (h.p1 != apdu_pkg::SEL_P1_EF || h.p2 != apdu_pkg::SEL_P2_NOFCI) begin
                        check_cmd = apdu_pkg::SW_BAD_P1P2;
                    end else if (h.p3 != apdu_pkg::SEL_LC || nb != apdu_pkg::SEL_LC) begin
                        check_cmd = apdu_pkg::SW_WRONG_LEN;
                    end else begin
                        check_cmd = apdu_pkg::SW_NORMAL;
                    end
                end
                apdu_pkg::INS_READ: begin
                    if (nb != 8'h00 || h.p3 < apdu_pkg::RD_LE_MIN || h.p3 > apdu_pkg::RD_LE_MAX) begin
                        check_cmd = apdu_pkg::SW_WRONG_LEN;
                    end else if (!tun && end_addr(h) > apdu_pkg::MEM_BYTES) begin
                        check_cmd = apdu_pkg::SW_BAD_ADDR;
                    end else begin
                        check_cmd = apdu_pkg::SW_NORMAL;
                    end
                end
                apdu_pkg::INS_WRITE: begin
                    if (h.p3 < apdu_pkg::WR_LC_MIN || h.p3 > apdu_pkg::WR_LC_MAX || nb != h.p3) begin
                        check_cmd = apdu_pkg::SW_WRONG_LEN;
                    end else if (!tun && end_addr(h) > apdu_pkg::MEM_BYTES) begin
                        check_cmd = apdu_pkg::SW_BAD_ADDR;
                    end else begin
                        check_cmd = apdu_pkg::SW_NORMAL;
                    end
                end
                default: check_cmd = apdu_pkg::SW_BAD_INS;
            endcase
        end
    endfunction : check_cmd

    // asynchronous read keeps read-out at one byte per cycle
    assign mem_q = mem[st.ptr[apdu_pkg::MEM_AW-1:0]];

    always_comb begin
        next_st            = st;
        next_st.tun_rd_req = 1'b0;
        next_st.tun_wr_valid = 1'b0;
        pop       = st.rsp_valid && rsp_ready_in;
        room      = (st.buf_cnt != apdu_pkg::BUF_DEPTH) || pop;
        cmd_take  = st.cmd_ready && cmd_valid_in;
        tun_take  = st.tun_rd_ready && tun_rd_valid_in;
        push      = 1'b0;
        push_byte = '0;
        mem_we    = 1'b0;
        wr_addr   = {st.hdr.p1, st.hdr.p2} + {8'h00, st.body_cnt};
        mem_wa    = wr_addr[apdu_pkg::MEM_AW-1:0];
        mem_wd    = cmd_in.data;
        unique case (st.state)
            apdu_pkg::ST_HDR: begin
                if (cmd_take) begin
                    next_st.hdr     = {st.hdr[31:0], cmd_in.data};
                    next_st.hdr_cnt = 3'(st.hdr_cnt + 3'h1);
                    if (cmd_in.last) begin
                        next_st.state = apdu_pkg::ST_EVAL;
                    end else if (st.hdr_cnt == 3'(apdu_pkg::HDR_LEN - 3'h1)) begin
                        next_st.state = apdu_pkg::ST_BODY;
                    end
                end
            end
            apdu_pkg::ST_BODY: begin
                if (cmd_take) begin
                    // select body bytes are counted only, never stored
                    if (write_ok(st.hdr, tunnel_mode_in) && st.body_cnt < st.hdr.p3) begin
                        if (tunnel_mode_in) begin
                            next_st.tun_wr_valid = 1'b1;
                            next_st.tun_wr       = cmd_in;
                        end else begin
                            mem_we = 1'b1;
                        end
                    end
                    if (st.body_cnt != apdu_pkg::CNT_SAT) begin
                        next_st.body_cnt = 8'(st.body_cnt + 8'h01);
                    end
                    if (cmd_in.last) begin
                        next_st.state = apdu_pkg::ST_EVAL;
                    end
                end
            end
            apdu_pkg::ST_EVAL: begin
                next_st.sw   = check_cmd(st.hdr, st.hdr_cnt, st.body_cnt, tunnel_mode_in);
                next_st.ptr  = {st.hdr.p1, st.hdr.p2};
                next_st.left = st.hdr.p3;
                next_st.state = apdu_pkg::ST_SW1;
                if (next_st.sw == apdu_pkg::SW_NORMAL && st.hdr.ins == apdu_pkg::INS_READ) begin
                    if (tunnel_mode_in) begin
                        next_st.tun_rd_req = 1'b1;
                        next_st.state      = apdu_pkg::ST_RD_TUN;
                    end else begin
                        next_st.state = apdu_pkg::ST_RD_MEM;
                    end
                end
            end
            apdu_pkg::ST_RD_MEM, apdu_pkg::ST_RD_TUN: begin
                if (st.state == apdu_pkg::ST_RD_MEM ? room : tun_take) begin
                    push      = 1'b1;
                    push_byte = '{data: (st.state == apdu_pkg::ST_RD_MEM) ? mem_q : tun_rd_data_in, last: 1'b0};
                    next_st.ptr  = 16'(st.ptr + 16'h0001);
                    next_st.left = 8'(st.left - 8'h01);
                    if (st.left == 8'h01) begin
                        next_st.state = apdu_pkg::ST_SW1;
                    end
                end
            end
            apdu_pkg::ST_SW1: begin
                if (room) begin
                    push          = 1'b1;
                    push_byte     = '{data: st.sw[15:8], last: 1'b0};
                    next_st.state = apdu_pkg::ST_SW2;
                end
            end
            apdu_pkg::ST_SW2: begin
                if (room) begin
                    push             = 1'b1;
                    push_byte        = '{data: st.sw[7:0], last: 1'b1};
                    next_st.state    = apdu_pkg::ST_HDR;
                    next_st.hdr_cnt  = '0;
                    next_st.body_cnt = '0;
                end
            end
        endcase
        // two-entry buffer: head always sits in slot 0
        widx = 2'(st.buf_cnt - {1'b0, pop});
        if (pop) begin
            next_st.buf_q[0] = st.buf_q[1];
        end
        if (push) begin
            next_st.buf_q[widx[0]] = push_byte;
        end
        next_st.buf_cnt   = 2'(st.buf_cnt + {1'b0, push} - {1'b0, pop});
        next_st.rsp_valid = next_st.buf_cnt != 2'h0;
        next_st.cmd_ready = next_st.state == apdu_pkg::ST_HDR || next_st.state == apdu_pkg::ST_BODY;
        // host bytes only accepted into an empty buffer, so a take always has room
        next_st.tun_rd_ready = next_st.state == apdu_pkg::ST_RD_TUN && next_st.buf_cnt == 2'h0;
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            st <= apdu_pkg::REG_RST;
        end else begin
            st <= next_st;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    assign cmd_ready_out    = st.cmd_ready;
    assign rsp_out          = st.buf_q[0];
    assign rsp_valid_out    = st.rsp_valid;
    assign tun_rd_req_out   = st.tun_rd_req;
    assign tun_rd_addr_out  = st.ptr;
    assign tun_rd_len_out   = st.left;
    assign tun_rd_ready_out = st.tun_rd_ready;
    assign tun_wr_out       = st.tun_wr;
    assign tun_wr_valid_out = st.tun_wr_valid;

    a_rsp_hold_stable:
    assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        rsp_valid_out && !rsp_ready_in |=> rsp_valid_out && $stable(rsp_out))
        else $error("response byte changed while stalled");

    a_select_normal_ok:
    assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        st.state == apdu_pkg::ST_EVAL && st.hdr_cnt == apdu_pkg::HDR_LEN && st.hdr.cla == apdu_pkg::CLA_OK
        && st.hdr.ins == apdu_pkg::INS_SELECT && st.hdr.p1 == apdu_pkg::SEL_P1_EF
        && st.hdr.p2 == apdu_pkg::SEL_P2_NOFCI && st.hdr.p3 == apdu_pkg::SEL_LC && st.body_cnt == apdu_pkg::SEL_LC
        |=> st.state == apdu_pkg::ST_SW1 && st.sw == apdu_pkg::SW_NORMAL ##1 !mem_we ##1 !mem_we)
        else $error("valid select not answered normally");

    a_class_error:
    assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        st.state == apdu_pkg::ST_EVAL && st.hdr_cnt == apdu_pkg::HDR_LEN && st.hdr.cla != apdu_pkg::CLA_OK
        |=> st.sw == apdu_pkg::SW_BAD_CLA && st.state == apdu_pkg::ST_SW1)
        else $error("bad class byte not rejected");

    a_select_p1_err:
    assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        st.state == apdu_pkg::ST_EVAL && st.hdr_cnt == apdu_pkg::HDR_LEN && st.hdr.cla == apdu_pkg::CLA_OK
        && st.hdr.ins == apdu_pkg::INS_SELECT && st.hdr.p1 != apdu_pkg::SEL_P1_EF
        |=> st.sw == apdu_pkg::SW_BAD_P1P2)
        else $error("select p1 not rejected");

    a_select_p2_err:
    assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        st.state == apdu_pkg::ST_EVAL && st.hdr_cnt == apdu_pkg::HDR_LEN && st.hdr.cla == apdu_pkg::CLA_OK
        && st.hdr.ins == apdu_pkg::INS_SELECT && st.hdr.p2 != apdu_pkg::SEL_P2_NOFCI
        |=> st.sw == apdu_pkg::SW_BAD_P1P2)
        else $error("select p2 not rejected");

    a_select_len_err:
    assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        st.state == apdu_pkg::ST_EVAL && st.hdr_cnt == apdu_pkg::HDR_LEN && st.hdr.cla == apdu_pkg::CLA_OK
        && st.hdr.ins == apdu_pkg::INS_SELECT && st.hdr.p1 == apdu_pkg::SEL_P1_EF
        && st.hdr.p2 == apdu_pkg::SEL_P2_NOFCI && (st.hdr.p3 != apdu_pkg::SEL_LC || st.body_cnt != apdu_pkg::SEL_LC)
        |=> st.sw == apdu_pkg::SW_WRONG_LEN)
        else $error("select length not rejected");

    // after an error status a stalled receiver may hold the machine in a status byte, never in a data state
    a_error_no_data:
    assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        st.state == apdu_pkg::ST_EVAL ##1 st.sw != apdu_pkg::SW_NORMAL
        |-> st.state == apdu_pkg::ST_SW1 ##1 (st.state == apdu_pkg::ST_SW1 || st.state == apdu_pkg::ST_SW2))
        else $error("error status followed by data");

    a_mem_write_mode:
    assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        mem_we |-> !tunnel_mode_in && st.state == apdu_pkg::ST_BODY && st.hdr.ins == apdu_pkg::INS_WRITE)
        else $error("memory written outside a plain write");

    a_tunnel_write_fwd:
    assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        cmd_take && st.state == apdu_pkg::ST_BODY && tunnel_mode_in && write_ok(st.hdr, 1'b1)
        && st.body_cnt < st.hdr.p3
        |=> tun_wr_valid_out && tun_wr_out.data == $past(cmd_in.data))
        else $error("tunnel write byte not forwarded");

    a_tunnel_read_req:
    assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        st.state == apdu_pkg::ST_EVAL && tunnel_mode_in && st.hdr.ins == apdu_pkg::INS_READ
        ##1 st.sw == apdu_pkg::SW_NORMAL
        |-> tun_rd_req_out && st.state == apdu_pkg::ST_RD_TUN && tun_rd_len_out == $past(st.hdr.p3))
        else $error("tunnel read not sent to host");
endmodule : apdu_select_read_write
`default_nettype wire

// file: testbench/apdu_host_model.sv
// wired host model: answers tunnel reads and records tunnel writes
`timescale 1ns/1ps
`default_nettype none
module apdu_host_model (
    input  wire logic                 clk_in,
    input  wire logic                 rst_b_in,
    input  wire logic                 slow_in,
    input  wire logic                 rd_req_in,
    input  wire logic [15:0]          rd_addr_in,
    input  wire logic [7:0]           rd_len_in,
    output logic      [7:0]           rd_data_out,
    output logic                      rd_valid_out,
    input  wire logic                 rd_ready_in,
    input  wire apdu_pkg::apdu_byte_t wr_in,
    input  wire logic                 wr_valid_in
);
    logic [15:0] addr;
    logic [7:0]  left;
    logic [1:0]  wait_cnt;
    logic [15:0] req_addr;
    logic [7:0]  req_len;
    logic [7:0]  wr_log [$];

    always @(posedge clk_in) begin
        if (!rst_b_in) begin
            rd_valid_out <= 1'b0;
            rd_data_out  <= 8'h00;
            left         <= 8'h00;
            wait_cnt     <= 2'h0;
        end else begin
            if (wr_valid_in) begin
                wr_log.push_back(wr_in.data);
            end
            if (rd_req_in) begin
                addr     <= rd_addr_in;
                left     <= rd_len_in;
                req_addr <= rd_addr_in;
                req_len  <= rd_len_in;
                wait_cnt <= {slow_in, slow_in};
            end else if (rd_valid_out && rd_ready_in) begin
                // byte taken: drop valid, line no longer shows the old value
                rd_valid_out <= 1'b0;
                rd_data_out  <= ~rd_data_out;
                addr         <= addr + 16'h0001;
                left         <= left - 8'h01;
                wait_cnt     <= {slow_in, 1'b0};
            end else if (!rd_valid_out && left != 8'h00) begin
                if (wait_cnt != 2'h0) begin
                    wait_cnt <= wait_cnt - 2'h1;
                end else begin
                    rd_valid_out <= 1'b1;
                    rd_data_out  <= addr[7:0] ^ 8'h5A;
                end
            end else if (!rd_valid_out) begin
                rd_data_out <= ~rd_data_out;
            end
        end
    end
endmodule : apdu_host_model
`default_nettype wire

// file: testbench/apdu_select_read_write_bench.sv
// self-checking bench for the select, read and write command interpreter
`timescale 1ns/1ps
`default_nettype none
module apdu_select_read_write_bench;
    typedef logic [7:0] apdu_bq_t [$];
    logic                 core_clk_in    = 1'b0;
    logic                 rst_b_in       = 1'b0;
    logic                 tunnel_mode_in = 1'b0;
    apdu_pkg::apdu_byte_t cmd_in         = '0;
    logic                 cmd_valid_in   = 1'b0;
    logic                 rsp_ready_in   = 1'b1;
    logic                 slow           = 1'b0;
    logic [7:0]           stall_cnt      = 8'h00;
    logic                 cmd_ready_out, rsp_valid_out, tun_rd_req_out, tun_rd_ready_out, tun_wr_valid_out;
    logic                 tun_rd_valid_in;
    logic [7:0]           tun_rd_len_out, tun_rd_data_in;
    logic [15:0]          tun_rd_addr_out;
    apdu_pkg::apdu_byte_t rsp_out, tun_wr_out;
    int                   mismatches = 0;
    int                   checked    = 0;
    logic                 rsp_done   = 1'b0;
    apdu_bq_t             rsp_q;

    apdu_select_read_write apdu_select_read_write_inst (.core_clk_in, .rst_b_in, .tunnel_mode_in, .cmd_in,
        .cmd_valid_in, .cmd_ready_out, .rsp_out, .rsp_valid_out, .rsp_ready_in, .tun_rd_req_out, .tun_rd_addr_out,
        .tun_rd_len_out, .tun_rd_data_in, .tun_rd_valid_in, .tun_rd_ready_out, .tun_wr_out, .tun_wr_valid_out);

    apdu_host_model apdu_host_model_inst (.clk_in(core_clk_in), .rst_b_in(rst_b_in), .slow_in(slow),
        .rd_req_in(tun_rd_req_out), .rd_addr_in(tun_rd_addr_out), .rd_len_in(tun_rd_len_out),
        .rd_data_out(tun_rd_data_in), .rd_valid_out(tun_rd_valid_in), .rd_ready_in(tun_rd_ready_out),
        .wr_in(tun_wr_out), .wr_valid_in(tun_wr_valid_out));

    always #5 core_clk_in = ~core_clk_in;

    // receiver stalls three cycles in four while slow, to fill the buffer
    always @(negedge core_clk_in) begin
        stall_cnt    <= stall_cnt + 8'h01;
        rsp_ready_in <= !slow || (stall_cnt[1:0] == 2'h0);
    end

    always @(posedge core_clk_in) begin
        if (rst_b_in && rsp_valid_out && rsp_ready_in) begin
            rsp_q.push_back(rsp_out.data);
            if (rsp_out.last) rsp_done = 1'b1;
        end
    end

    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check_byte

    task automatic check_num(input string what, input int exp, input int got);
        checked++;
        if (got != exp) begin
            mismatches++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_num

    function automatic apdu_bq_t hdr(input logic [7:0] cla, ins, p1, p2, p3);
        apdu_bq_t q;
        q = {cla, ins, p1, p2, p3};
        return q;
    endfunction : hdr

    function automatic apdu_bq_t sw(input logic [15:0] w);
        apdu_bq_t q;
        q = {w[15:8], w[7:0]};
        return q;
    endfunction : sw

    // one whole command, then wait for the response ending in the last flag
    task automatic exchange(input apdu_bq_t c, input apdu_bq_t e);
        int n;
        rsp_q.delete();
        rsp_done = 1'b0;
        foreach (c[i]) begin
            @(negedge core_clk_in);
            cmd_in       <= '{data: c[i], last: (i == c.size() - 1)};
            cmd_valid_in <= 1'b1;
            n = 0;
            do begin
                @(posedge core_clk_in);
                n++;
            end while (cmd_ready_out !== 1'b1 && n < 400);
            check_byte("response during command", 8'h00, {7'h00, rsp_valid_out});
        end
        @(negedge core_clk_in);
        cmd_valid_in <= 1'b0;
        n = 0;
        while (!rsp_done && n < 3000) begin
            @(negedge core_clk_in);
            n++;
        end
        check_num("response length", e.size(), rsp_q.size());
        foreach (e[i]) if (i < rsp_q.size()) check_byte("response byte", e[i], rsp_q[i]);
    endtask : exchange

    initial begin
        #200_000;
        mismatches++;
        report_and_stop();
    end

    initial begin
        apdu_bq_t   c;
        apdu_bq_t   e;
        logic [7:0] ins_tab [3];
        ins_tab = '{8'hA4, 8'hB0, 8'hD6};
        repeat (12) @(posedge core_clk_in);
        @(negedge core_clk_in);
        rst_b_in <= 1'b1;
        repeat (2) @(negedge core_clk_in);
        exchange({hdr(8'h00, 8'hA4, 8'h02, 8'h0C, 8'h02), 8'h3F, 8'hFF}, sw(apdu_pkg::SW_NORMAL));
        exchange({hdr(8'h00, 8'hA4, 8'h02, 8'h0C, 8'h02), 8'h00, 8'hE1}, sw(apdu_pkg::SW_NORMAL));
        exchange({hdr(8'h00, 8'hA4, 8'h01, 8'h0C, 8'h02), 8'h00, 8'h01}, sw(apdu_pkg::SW_BAD_P1P2));
        exchange({hdr(8'h00, 8'hA4, 8'h02, 8'h00, 8'h02), 8'h00, 8'h01}, sw(apdu_pkg::SW_BAD_P1P2));
        exchange({hdr(8'h00, 8'hA4, 8'h02, 8'h0C, 8'h01), 8'h00}, sw(apdu_pkg::SW_WRONG_LEN));
        exchange({hdr(8'h00, 8'hA4, 8'h02, 8'h0C, 8'h03), 8'h00, 8'h01, 8'h02}, sw(apdu_pkg::SW_WRONG_LEN));
        // every command with a class byte other than zero
        foreach (ins_tab[k]) begin
            c = hdr(8'h01 << (3 * k), ins_tab[k], 8'h02, 8'h0C, 8'h02);
            if (k != 1) c = {c, 8'h00, 8'h00};
            exchange(c, sw(apdu_pkg::SW_BAD_CLA));
        end
        exchange(hdr(8'h00, 8'hCA, 8'h00, 8'h00, 8'h01), sw(apdu_pkg::SW_BAD_INS));
        exchange({8'h00, 8'hB0, 8'h00}, sw(apdu_pkg::SW_WRONG_LEN));
        // longest write fills 0x000..0x0F7
        c = hdr(8'h00, 8'hD6, 8'h00, 8'h00, 8'hF8);
        for (int i = 0; i < 248; i++) c.push_back(8'(i) ^ 8'hA5);
        exchange(c, sw(apdu_pkg::SW_NORMAL));
        exchange({hdr(8'h00, 8'hD6, 8'h01, 8'h23, 8'h02), 8'h11, 8'h22}, sw(apdu_pkg::SW_NORMAL));
        slow <= 1'b1;
        e = {8'h03 ^ 8'hA5, 8'h04 ^ 8'hA5, 8'h05 ^ 8'hA5, 8'h06 ^ 8'hA5, 8'h07 ^ 8'hA5};
        exchange(hdr(8'h00, 8'hB0, 8'h00, 8'h03, 8'h05), {e, sw(apdu_pkg::SW_NORMAL)});
        exchange(hdr(8'h00, 8'hB0, 8'h01, 8'h23, 8'h02), {8'h11, 8'h22, sw(apdu_pkg::SW_NORMAL)});
        slow <= 1'b0;
        exchange(hdr(8'h00, 8'hB0, 8'h00, 8'h00, 8'h00), sw(apdu_pkg::SW_WRONG_LEN));
        exchange(hdr(8'h00, 8'hB0, 8'h00, 8'h00, 8'hFC), sw(apdu_pkg::SW_WRONG_LEN));
        exchange(hdr(8'h00, 8'hD6, 8'h00, 8'h00, 8'h00), sw(apdu_pkg::SW_WRONG_LEN));
        exchange(hdr(8'h00, 8'hB0, 8'h07, 8'hFF, 8'h02), sw(apdu_pkg::SW_BAD_ADDR));
        // tunnel: longest read served by the slow host, then a forwarded write
        @(negedge core_clk_in);
        tunnel_mode_in <= 1'b1;
        slow           <= 1'b1;
        e.delete();
        for (int i = 0; i < 251; i++) e.push_back((8'h34 + 8'(i)) ^ 8'h5A);
        exchange(hdr(8'h00, 8'hB0, 8'h12, 8'h34, 8'hFB), {e, sw(apdu_pkg::SW_NORMAL)});
        check_byte("host read length", 8'hFB, apdu_host_model_inst.req_len);
        check_byte("host read address", 8'h12, apdu_host_model_inst.req_addr[15:8]);
        check_byte("host read address low", 8'h34, apdu_host_model_inst.req_addr[7:0]);
        slow <= 1'b0;
        exchange({hdr(8'h00, 8'hD6, 8'h01, 8'h23, 8'h03), 8'hC1, 8'hC2, 8'hC3}, sw(apdu_pkg::SW_NORMAL));
        check_num("host write count", 3, apdu_host_model_inst.wr_log.size());
        foreach (apdu_host_model_inst.wr_log[i]) check_byte("host write", 8'hC1 + 8'(i), apdu_host_model_inst.wr_log[i]);
        @(negedge core_clk_in);
        tunnel_mode_in <= 1'b0;
        exchange(hdr(8'h00, 8'hB0, 8'h01, 8'h23, 8'h02), {8'h11, 8'h22, sw(apdu_pkg::SW_NORMAL)});
        report_and_stop();
    end
endmodule : apdu_select_read_write_bench
`default_nettype wire
